/* lfcd_pkg.sv */
// Constants, register map and types of the carrier detector and gain control block.
package lfcd_pkg;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int TLIMIT_US = 256;
    localparam int TLIMIT_CYC = (TLIMIT_US * 1000) / CLK_PERIOD_NS;
    localparam logic [5:0] SETTLE_PER = 6'h23;
    localparam logic [5:0] SELECT_PER = 6'h20;
    localparam logic [1:0] NOCAR_HALF = 2'h3;
    localparam logic [4:0] GAIN_MAX = 5'h1F;
    // ****************************************
    // Register map and fields
    // ****************************************
    localparam logic [5:0] ADDR_CFG = 6'h00;
    localparam logic [5:0] ADDR_AGC = 6'h01;
    localparam logic [5:0] ADDR_TOL = 6'h02;
    localparam logic [5:0] ADDR_GAIN = 6'h04;
    localparam logic [5:0] ADDR_BAND = 6'h08;
    localparam logic [5:0] ADDR_STR1 = 6'h0A;
    localparam logic [5:0] ADDR_STR2 = 6'h0B;
    localparam logic [5:0] ADDR_STR3 = 6'h0C;
    localparam logic [5:0] ADDR_STAT = 6'h14;
    localparam int TLIM_BIT = 3;
    localparam int AGC_UD_BIT = 5;
    localparam int DAMP_EN_BIT = 4;
    localparam int BOOST_BIT = 5;
    localparam int DRES_LSB = 4;
    localparam int BAND_LSB = 5;
    localparam logic [2:0] CH_EN_RST = 3'h7;
    localparam logic [2:0] BAND_LOW = 3'h7;
    // ****************************************
    // Direct commands
    // ****************************************
    localparam logic [1:0] CMD_MODE = 2'h3;
    localparam logic [5:0] CMD_CLEAR_WAKE = 6'h00;
    localparam logic [5:0] CMD_STR_RESET = 6'h01;
    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic [2:0] ch_en;
        logic tlim;
        logic agc_ud;
        logic damp_en;
        logic boost;
        logic [1:0] tol;
        logic [1:0] damp_res;
        logic [3:0] start_red;
        logic [2:0] band;
    } lfcd_cfg_type;
    typedef enum logic [1:0] {
        ST_LISTEN = 2'h0,
        ST_SETTLE = 2'h1,
        ST_SELECT = 2'h3,
        ST_TRACK = 2'h2
    } lfcd_state_type;
endpackage : lfcd_pkg

/* lfcd_top.sv */
// Carrier detection, gain control and channel selection of a three-channel wake-up receiver.
// Function
// - In listening mode every channel gain stays at its starting gain.
// - Gain control starts only after carrier detection and then lowers the gain.
// - Strength value is the inverse of the gain setting.
// - Band field selects window multiplier four, six, ten, eighteen or fourteen.
// - Boost bit adds gain; lowest band forces boost on.
// - Each channel enables separately; disabled channels skip detection and selection.
// - Zero crossings are counted in windows of N clock generator periods.
// - Detection needs a matching count in two consecutive windows.
// - Upper bands: tolerance field gives sixteen plus or minus six, four, two.
// - Lowest band: tolerance field gives eight plus or minus three, two, one.
// - Gain settles from the starting gain within thirty-five carrier periods.
// - Mode bit: zero allows only decreasing gain, one allows both directions.
// - Three five-bit strength values are held, each in its own register.
// - After settling, weaker active channels freeze; only the strongest keeps control.
// - Clear-wake or strength reset restores gain control; clear-wake returns to listening.
// - Optional time limit stops gain control 256 us after detection.
// - Strength reset restores gain only, keeping the detected carrier condition.
// - During data, three half-symbols without carrier reset the gain.
// - Clearing the wake state returns to listening with detection re-armed.
// - Four-bit starting-gain field reduces start gain in four decibel steps.
// - Damper enable bit and two-bit resistor selection drive the antenna damper.
// - Strongest channel connects to the demodulator after thirty-two carrier periods.
// - Direct commands carry mode bits 11 and a six-bit command code.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
module lfcd_top #(
    parameter int TLIMIT_CYC = lfcd_pkg::TLIMIT_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic reset,
    // Register port.
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Direct command port.
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_word,
    // Analog front end.
    input wire logic [2:0] lf_in,
    input wire logic clk_gen,
    input wire logic [2:0] level_high,
    input wire logic [2:0] level_low,
    // Data receiver.
    input wire logic data_rx,
    input wire logic half_sym_tick,
    // Amplifier and damper controls.
    output logic [2:0][4:0] vga_gain,
    output logic gain_boost,
    output logic damper_en,
    output logic [1:0] damper_res,
    output logic [2:0] ch_power,
    // Demodulator feed and status.
    output logic demod_carrier,
    output logic [1:0] demod_ch,
    output logic freq_det
);
    localparam int TL_W = $clog2(TLIMIT_CYC + 1);

    generate
        if (TLIMIT_CYC < 1) begin : g_bad_tlimit
            $error("TLIMIT_CYC must be at least one");
        end
    endgenerate

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [4:0] band_n(input logic [2:0] b);
        case (b)
            3'h0: band_n = 5'h04;
            3'h1: band_n = 5'h06;
            3'h2: band_n = 5'h0A;
            3'h3: band_n = 5'h12;
            3'h7: band_n = 5'h0E;
            default: band_n = 5'h04;
        endcase
    endfunction : band_n

    function automatic logic in_window(input logic [5:0] n, input logic [2:0] b, input logic [1:0] t);
        logic [5:0] ctr;
        logic [5:0] tol;
        ctr = (b == lfcd_pkg::BAND_LOW) ? 6'h08 : 6'h10;
        if (b == lfcd_pkg::BAND_LOW) begin
            tol = (t == 2'h0) ? 6'h03 : (t == 2'h1) ? 6'h02 : 6'h01;
        end else begin
            tol = (t == 2'h0) ? 6'h06 : (t == 2'h1) ? 6'h04 : 6'h02;
        end
        in_window = (n >= ctr - tol) && (n <= ctr + tol);
    endfunction : in_window

    function automatic logic [1:0] lowest(input logic [2:0] m);
        lowest = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h0;
    endfunction : lowest

    function automatic logic [1:0] strongest(input logic [2:0][4:0] r, input logic [2:0] en);
        logic [1:0] best;
        best = lowest(en);
        for (int c = 0; c < 3; c++) begin
            if (en[c] && r[c] > r[best]) begin
                best = 2'(c);
            end
        end
        strongest = best;
    endfunction : strongest

    // ****************************************
    // Input synchronisers
    // ****************************************
    logic [9:0] s1, s2, s3, in_q, in_d;
    wire [9:0] raw = {level_low, level_high, clk_gen, lf_in};
    wire [9:0] next_in_q = (s2 & s3) | (in_q & (s2 ^ s3));
    wire [9:0] rise = in_q & ~in_d;
    wire [2:0] lf_rise = rise[2:0];
    wire cg_rise = rise[3];
    wire [2:0] lvl_hi = in_q[6:4];
    wire [2:0] lvl_lo = in_q[9:7];

    always_ff @(posedge mclk) begin
        if (reset) begin
            s1 <= 10'h000;
            s2 <= 10'h000;
            s3 <= 10'h000;
            in_q <= 10'h000;
            in_d <= 10'h000;
        end else begin
            s1 <= raw;
            s2 <= s1;
            s3 <= s2;
            in_q <= next_in_q;
            in_d <= in_q;
        end
    end

    // ****************************************
    // Registers and commands
    // ****************************************
    lfcd_pkg::lfcd_cfg_type cfg;
    lfcd_pkg::lfcd_state_type state, next_state;
    logic [2:0] frozen;
    wire cmd_hit = cmd_valid && cmd_word[7:6] == lfcd_pkg::CMD_MODE;
    wire clr = cmd_hit && cmd_word[5:0] == lfcd_pkg::CMD_CLEAR_WAKE;
    wire srst = cmd_hit && cmd_word[5:0] == lfcd_pkg::CMD_STR_RESET;
    wire [2:0][4:0] strength = ~vga_gain;
    wire [7:0] stat = {freq_det, frozen, demod_ch, state};
    wire [7:0] rd_mux =
        (reg_addr == lfcd_pkg::ADDR_CFG) ? {4'h0, cfg.tlim, cfg.ch_en} :
        (reg_addr == lfcd_pkg::ADDR_AGC) ? {2'h0, cfg.agc_ud, cfg.damp_en, 4'h0} :
        (reg_addr == lfcd_pkg::ADDR_TOL) ? {2'h0, cfg.boost, 3'h0, cfg.tol} :
        (reg_addr == lfcd_pkg::ADDR_GAIN) ? {2'h0, cfg.damp_res, cfg.start_red} :
        (reg_addr == lfcd_pkg::ADDR_BAND) ? {cfg.band, 5'h00} :
        (reg_addr == lfcd_pkg::ADDR_STR1) ? {3'h0, strength[0]} :
        (reg_addr == lfcd_pkg::ADDR_STR2) ? {3'h0, strength[1]} :
        (reg_addr == lfcd_pkg::ADDR_STR3) ? {3'h0, strength[2]} :
        (reg_addr == lfcd_pkg::ADDR_STAT) ? stat : 8'h00;

    always_ff @(posedge mclk) begin
        if (reset) begin
            cfg <= '{ch_en: lfcd_pkg::CH_EN_RST, default: '0};
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
            if (reg_wr) begin
                case (reg_addr)
                    lfcd_pkg::ADDR_CFG: begin
                        cfg.ch_en <= reg_wdata[2:0];
                        cfg.tlim <= reg_wdata[lfcd_pkg::TLIM_BIT];
                    end
                    lfcd_pkg::ADDR_AGC: begin
                        cfg.agc_ud <= reg_wdata[lfcd_pkg::AGC_UD_BIT];
                        cfg.damp_en <= reg_wdata[lfcd_pkg::DAMP_EN_BIT];
                    end
                    lfcd_pkg::ADDR_TOL: begin
                        cfg.boost <= reg_wdata[lfcd_pkg::BOOST_BIT];
                        cfg.tol <= reg_wdata[1:0];
                    end
                    lfcd_pkg::ADDR_GAIN: begin
                        cfg.damp_res <= reg_wdata[lfcd_pkg::DRES_LSB +: 2];
                        cfg.start_red <= reg_wdata[3:0];
                    end
                    lfcd_pkg::ADDR_BAND: cfg.band <= reg_wdata[lfcd_pkg::BAND_LSB +: 3];
                    default: cfg <= cfg;
                endcase
            end
        end
    end

    assign damper_en = cfg.damp_en;
    assign damper_res = cfg.damp_res;
    assign ch_power = cfg.ch_en;

    // ****************************************
    // Frequency detector
    // ****************************************
    logic [4:0] win_cnt;
    logic [2:0][5:0] zc_cnt;
    logic [2:0] hit, det_ch, win_ok;
    wire win_end = cg_rise && win_cnt >= band_n(cfg.band) - 5'h01;
    wire [2:0] win_pass = win_ok & hit & cfg.ch_en;
    wire freq_hit = state == lfcd_pkg::ST_LISTEN && win_end && |win_pass;

    always_comb begin
        win_ok = 3'h0;
        for (int c = 0; c < 3; c++) begin
            win_ok[c] = in_window(zc_cnt[c], cfg.band, cfg.tol);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset || clr) begin
            win_cnt <= 5'h00;
            zc_cnt <= '0;
            hit <= 3'h0;
            det_ch <= 3'h0;
            freq_det <= 1'b0;
        end else begin
            if (cg_rise) begin
                win_cnt <= win_end ? 5'h00 : win_cnt + 5'h01;
            end
            for (int c = 0; c < 3; c++) begin
                if (win_end) begin
                    zc_cnt[c] <= {5'h00, lf_rise[c]};
                    hit[c] <= win_ok[c];
                end else if (lf_rise[c] && zc_cnt[c] != 6'h3F) begin
                    zc_cnt[c] <= zc_cnt[c] + 6'h01;
                end
            end
            if (freq_hit) begin
                det_ch <= win_pass;
                freq_det <= 1'b1;
            end
        end
    end

    // ****************************************
    // Sequencing of settle and select
    // ****************************************
    logic [5:0] per_cnt;
    logic [1:0] nocar_cnt;
    logic car_seen;
    logic [TL_W-1:0] tl_cnt;
    wire ref_tick = lf_rise[lowest(det_ch & cfg.ch_en)];
    wire [5:0] per_lim = (state == lfcd_pkg::ST_SETTLE) ? lfcd_pkg::SETTLE_PER : lfcd_pkg::SELECT_PER;
    wire per_done = ref_tick && per_cnt == per_lim - 6'h01;
    wire car_now = car_seen || lf_rise[demod_ch];
    wire in_data = state == lfcd_pkg::ST_TRACK && data_rx;
    wire nocar_rst = in_data && half_sym_tick && !car_now && nocar_cnt == lfcd_pkg::NOCAR_HALF - 2'h1;
    wire agc_restart = srst || nocar_rst;
    wire restore = clr || agc_restart;
    wire tl_exp = cfg.tlim && tl_cnt == TL_W'(TLIMIT_CYC);
    wire [1:0] best_ch = strongest(strength, cfg.ch_en);
    wire sel_done = state == lfcd_pkg::ST_SELECT && per_done;

    always_comb begin
        next_state = state;
        case (state)
            lfcd_pkg::ST_LISTEN: if (freq_hit) next_state = lfcd_pkg::ST_SETTLE;
            lfcd_pkg::ST_SETTLE: if (per_done) next_state = lfcd_pkg::ST_SELECT;
            lfcd_pkg::ST_SELECT: if (per_done) next_state = lfcd_pkg::ST_TRACK;
            lfcd_pkg::ST_TRACK: next_state = lfcd_pkg::ST_TRACK;
            default: next_state = lfcd_pkg::ST_LISTEN;
        endcase
        if (clr) begin
            next_state = lfcd_pkg::ST_LISTEN;
        end else if (agc_restart && state != lfcd_pkg::ST_LISTEN) begin
            next_state = lfcd_pkg::ST_SETTLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state <= lfcd_pkg::ST_LISTEN;
            per_cnt <= 6'h00;
            tl_cnt <= '0;
            nocar_cnt <= 2'h0;
            car_seen <= 1'b0;
        end else begin
            state <= next_state;
            per_cnt <= (state != next_state || restore) ? 6'h00 : per_cnt + {5'h00, ref_tick};
            if (state == lfcd_pkg::ST_LISTEN || restore) begin
                tl_cnt <= '0;
            end else if (cfg.tlim && !tl_exp) begin
                tl_cnt <= tl_cnt + TL_W'(1);
            end
            if (!in_data) begin
                nocar_cnt <= 2'h0;
                car_seen <= 1'b0;
            end else if (half_sym_tick) begin
                nocar_cnt <= (car_now || nocar_rst) ? 2'h0 : nocar_cnt + 2'h1;
                car_seen <= 1'b0;
            end else begin
                car_seen <= car_now;
            end
        end
    end

    // ****************************************
    // Gain control and channel selector
    // ****************************************
    wire [2:0] red_step = (cfg.start_red[3:1] >= 3'h2) ? cfg.start_red[3:1] - 3'h1 : 3'h0;
    wire [4:0] start_gain = lfcd_pkg::GAIN_MAX - {red_step, 2'h0};
    wire [2:0] agc_run = {3{state != lfcd_pkg::ST_LISTEN && !tl_exp}} & cfg.ch_en & ~frozen;

    always_ff @(posedge mclk) begin
        if (reset) begin
            vga_gain <= {3{lfcd_pkg::GAIN_MAX}};
            frozen <= 3'h0;
            demod_ch <= 2'h0;
            demod_carrier <= 1'b0;
            gain_boost <= 1'b0;
        end else begin
            gain_boost <= cfg.boost || cfg.band == lfcd_pkg::BAND_LOW;
            demod_carrier <= (state == lfcd_pkg::ST_TRACK) && in_q[demod_ch];
            for (int c = 0; c < 3; c++) begin
                if (state == lfcd_pkg::ST_LISTEN || restore) begin
                    vga_gain[c] <= start_gain;
                end else if (agc_run[c] && lf_rise[c]) begin
                    if (lvl_hi[c] && vga_gain[c] != 5'h00) begin
                        vga_gain[c] <= vga_gain[c] - 5'h01;
                    end else if (cfg.agc_ud && lvl_lo[c] && vga_gain[c] != lfcd_pkg::GAIN_MAX) begin
                        vga_gain[c] <= vga_gain[c] + 5'h01;
                    end
                end
            end
            if (state == lfcd_pkg::ST_LISTEN || restore) begin
                frozen <= 3'h0;
            end else if (sel_done) begin
                frozen <= cfg.ch_en & ~(3'h1 << best_ch);
                demod_ch <= best_ch;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    listen_gain_a: assert property (state == lfcd_pkg::ST_LISTEN |=> vga_gain == {3{$past(start_gain)}})
        else $error("gain not at starting value while listening");
    boost_force_a: assert property (cfg.band == lfcd_pkg::BAND_LOW |=> gain_boost)
        else $error("boost not forced in lowest band");
    strength_inv_a: assert property (reg_rd && reg_addr == lfcd_pkg::ADDR_STR2 |=>
        reg_rdata == {3'h0, ~$past(vga_gain[1])})
        else $error("strength read is not inverse gain");
    det_window_a: assert property ($rose(freq_det) |-> $past(win_end) && $past(|(hit & cfg.ch_en)))
        else $error("detection without two matching windows");
    down_only_a: assert property (!cfg.agc_ud && state != lfcd_pkg::ST_LISTEN && !restore |=>
        vga_gain[0] <= $past(vga_gain[0]) && vga_gain[2] <= $past(vga_gain[2]))
        else $error("gain rose in down-only mode");
    clear_listen_a: assert property (clr |=> state == lfcd_pkg::ST_LISTEN && !freq_det && frozen == 3'h0)
        else $error("clear-wake did not return to listening");
    srst_keep_a: assert property (srst && !clr && freq_det |=> freq_det && state == lfcd_pkg::ST_SETTLE)
        else $error("strength reset lost detection");
    tlim_hold_a: assert property (tl_exp && !restore && state != lfcd_pkg::ST_LISTEN |=> $stable(vga_gain))
        else $error("gain moved after time limit");
    select_best_a: assert property (sel_done && !restore |=> demod_ch == $past(best_ch) &&
        frozen[demod_ch] == 1'b0 && state == lfcd_pkg::ST_TRACK)
        else $error("selector did not pick strongest channel");
    settle_bound_a: assert property (state == lfcd_pkg::ST_SETTLE |-> per_cnt < lfcd_pkg::SETTLE_PER)
        else $error("settling ran past its period count");

    detect_c: cover property (freq_hit);
    track_c: cover property (state == lfcd_pkg::ST_SELECT ##1 state == lfcd_pkg::ST_TRACK);
    nocar_c: cover property (nocar_rst);
    tlim_c: cover property ($rose(tl_exp));
endmodule : lfcd_top

/* lfcd_lf_model.sv */
// Behavioural LF resonators and clock generator feeding the receiver inputs.
`timescale 1ns/1ps
module lfcd_lf_model (
    // Clock.
    input wire logic mclk,
    // Carrier control.
    input wire logic [2:0] car_on,
    input wire logic [3:0] lf_half,
    // Resonator and clock generator outputs.
    output logic [2:0] lf_in,
    output logic clk_gen
);
    logic [4:0] gen_cnt = 5'h00;
    logic [3:0] lf_cnt = 4'h0;
    logic lf_wave = 1'b0;
    // Free running time base of 32 master clock cycles.
    assign clk_gen = gen_cnt[4];
    // A channel without carrier stands low.
    assign lf_in = car_on & {3{lf_wave}};
    always @(posedge mclk) begin
        gen_cnt <= gen_cnt + 5'h01;
        if (lf_cnt >= lf_half - 4'h1) begin
            lf_cnt <= 4'h0;
            lf_wave <= ~lf_wave;
        end else begin
            lf_cnt <= lf_cnt + 4'h1;
        end
    end
endmodule : lfcd_lf_model

/* lfcd_top_tb_top.sv */
// Self-checking testbench of the carrier detector and gain control block.
`timescale 1ns/1ps
module lfcd_top_tb_top;
    logic mclk, reset, reg_wr, reg_rd, cmd_valid, data_rx, half_sym_tick, clk_gen;
    logic gain_boost, damper_en, demod_carrier, freq_det;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, cmd_word, rd_val;
    logic [2:0] lf_in, level_high, level_low, ch_power, car_on;
    logic [2:0][4:0] vga_gain;
    logic [1:0] damper_res, demod_ch;
    logic [3:0] lf_half;
    int n_mismatch = 0;
    int checks_done = 0;
    int cycles = 0;
    int i;
    lfcd_top #(.TLIMIT_CYC(50)) u_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .lf_in(lf_in), .clk_gen(clk_gen), .level_high(level_high), .level_low(level_low), .data_rx(data_rx),
        .half_sym_tick(half_sym_tick), .vga_gain(vga_gain), .gain_boost(gain_boost), .damper_en(damper_en),
        .damper_res(damper_res), .ch_power(ch_power), .demod_carrier(demod_carrier), .demod_ch(demod_ch),
        .freq_det(freq_det));
    lfcd_lf_model u_lf (.mclk(mclk), .car_on(car_on), .lf_half(lf_half), .lf_in(lf_in), .clk_gen(clk_gen));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            wrap_up();
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic wrap_up();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Kind 0 writes, 1 reads, 2 sends a direct command; read data land in rd_val.
    task automatic bus(input int kind, input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        cmd_word <= d;
        reg_wr <= (kind == 0);
        reg_rd <= (kind == 1);
        cmd_valid <= (kind == 2);
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        cmd_valid <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask : bus
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        settle(2);
        for (i = 0; i < 3; i++) check("reset gain", 8'h1F, {3'h0, vga_gain[i]});
        check("reset outputs", 8'h1C, {3'h0, ch_power, gain_boost, freq_det});
        for (i = 0; i < 3; i++) begin
            bus(1, lfcd_pkg::ADDR_STR1 + 6'(i), 8'h00);
            check("strength", 8'h00, rd_val);
        end
        bus(0, 6'h3F, 8'hFF);
        bus(1, 6'h3F, 8'h00);
        check("unmapped", 8'h00, rd_val);
        bus(0, lfcd_pkg::ADDR_STR1, 8'hFF);
        bus(1, lfcd_pkg::ADDR_STR1, 8'h00);
        check("read only", 8'h00, rd_val);
    endtask : t_reset
    task automatic t_config();
        bus(0, lfcd_pkg::ADDR_BAND, 8'hE0);
        settle(2);
        check("boost low band", 8'h01, {7'h0, gain_boost});
        bus(0, lfcd_pkg::ADDR_BAND, 8'h00);
        bus(0, lfcd_pkg::ADDR_TOL, 8'h20);
        settle(2);
        check("boost bit", 8'h01, {7'h0, gain_boost});
        bus(0, lfcd_pkg::ADDR_TOL, 8'h00);
        settle(2);
        check("boost off", 8'h00, {7'h0, gain_boost});
        bus(0, lfcd_pkg::ADDR_AGC, 8'h10);
        for (i = 0; i < 4; i++) begin
            bus(0, lfcd_pkg::ADDR_GAIN, 8'(i << 4));
            settle(2);
            check("damper", 8'(4 + i), {5'h0, damper_en, damper_res});
        end
        for (i = 2; i < 8; i++) begin
            bus(0, lfcd_pkg::ADDR_GAIN, 8'(i * 2 + 1));
            settle(3);
            check("start gain", 8'(35 - 4 * i), {3'h0, vga_gain[0]});
        end
        bus(0, lfcd_pkg::ADDR_GAIN, 8'h00);
        bus(0, lfcd_pkg::ADDR_AGC, 8'h00);
    endtask : t_config
    task automatic t_detect();
        bus(0, lfcd_pkg::ADDR_CFG, 8'h05);
        bus(0, lfcd_pkg::ADDR_TOL, 8'h02);
        @(posedge mclk);
        car_on <= 3'h7;
        level_high <= 3'h6;
        settle(1000);
        check("tight tolerance", 8'h00, {7'h0, freq_det});
        check("listening gain", 8'h1F, {3'h0, vga_gain[2]});
        bus(0, lfcd_pkg::ADDR_TOL, 8'h01);
        for (i = 0; i < 3000 && freq_det !== 1'b1; i++) @(posedge mclk);
        settle(1);
        check("detected", 8'h01, {7'h0, freq_det});
        rd_val = 8'h00;
        for (i = 0; i < 500 && rd_val[1:0] !== 2'h2; i++) bus(1, lfcd_pkg::ADDR_STAT, 8'h00);
        check("selected", 8'h02, {6'h0, demod_ch});
        rd_val = 8'h00;
        for (i = 0; i < 12; i++) begin
            @(posedge mclk);
            #1;
            rd_val = rd_val | {6'h0, demod_carrier, ~demod_carrier};
        end
        check("demod feed", 8'h03, rd_val);
        check("gain settled", 8'h00, {3'h0, vga_gain[2]});
        check("disabled gain", 8'h1F, {3'h0, vga_gain[1]});
        bus(1, lfcd_pkg::ADDR_STR3, 8'h00);
        check("strength ch3", 8'h1F, rd_val);
        @(posedge mclk);
        level_high <= 3'h1;
        level_low <= 3'h4;
        settle(300);
        check("frozen ch", 8'h1F, {3'h0, vga_gain[0]});
        check("down only", 8'h00, {3'h0, vga_gain[2]});
        bus(0, lfcd_pkg::ADDR_AGC, 8'h20);
        settle(400);
        check("up and down", 8'h1F, {3'h0, vga_gain[2]});
    endtask : t_detect
    task automatic t_cmds();
        @(posedge mclk);
        level_high <= 3'h4;
        level_low <= 3'h0;
        settle(100);
        bus(2, 6'h00, 8'h41);
        check("bad mode", 8'h01, {7'h0, vga_gain[2] != 5'h1F});
        bus(0, lfcd_pkg::ADDR_CFG, 8'h0D);
        bus(2, 6'h00, 8'hC1);
        check("strength reset", 8'h3F, {2'h0, freq_det, vga_gain[2]});
        settle(600);
        check("time limit", 8'h01, {7'h0, vga_gain[2] != 5'h00 && vga_gain[2] != 5'h1F});
        bus(0, lfcd_pkg::ADDR_CFG, 8'h05);
        bus(2, 6'h00, 8'hC1);
        settle(800);
        check("new strength", 8'h00, {3'h0, vga_gain[2]});
        @(posedge mclk);
        data_rx <= 1'b1;
        car_on <= 3'h0;
        repeat (20) @(posedge mclk);
        for (i = 0; i < 3; i++) begin
            half_sym_tick <= 1'b1;
            @(posedge mclk);
            half_sym_tick <= 1'b0;
            repeat (4) @(posedge mclk);
        end
        settle(1);
        check("no carrier", 8'h3F, {2'h0, freq_det, vga_gain[2]});
        bus(2, 6'h00, 8'hC0);
        check("clear wake", 8'h1F, {2'h0, freq_det, vga_gain[2]});
        bus(1, lfcd_pkg::ADDR_STAT, 8'h00);
        check("listening", 8'h00, {6'h0, rd_val[1:0]});
        check("demod idle", 8'h00, {7'h0, demod_carrier});
        @(posedge mclk);
        car_on <= 3'h7;
        data_rx <= 1'b0;
        level_high <= 3'h0;
        rd_val = 8'h00;
        for (i = 0; i < 800 && rd_val[1:0] !== 2'h2; i++) bus(1, lfcd_pkg::ADDR_STAT, 8'h00);
        check("tie select", 8'h00, {6'h0, demod_ch});
    endtask : t_cmds
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset = 1'b1;
        {reg_wr, reg_rd, cmd_valid, data_rx, half_sym_tick} = 5'h00;
        reg_addr = 6'h00;
        {reg_wdata, cmd_word} = 16'h0000;
        {car_on, level_high, level_low} = 9'h000;
        lf_half = 4'h5;
        repeat (10) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_config();
        t_detect();
        t_cmds();
        wrap_up();
    end
endmodule : lfcd_top_tb_top
